// ---- rtl/csb_unit.sv ----
// Functional notes
// - Compares compute a-b-C or a-K, set Z N V S C H, one cycle.
// - Register bit-clear skip skips when bit is zero; flags untouched.
// - Register bit-set skip skips when bit is one; flags untouched.
// - I/O bit-clear skip skips when I/O bit is zero; flags untouched.
// - I/O bit-set skip skips when I/O bit is one; flags untouched.
// - Flag-set branch jumps to PC+k+1 when indexed flag is one.
// - Flag-clear branch jumps to PC+k+1 when indexed flag is zero.
// - Equal branch jumps when Z is one.
// - Not-equal branch jumps when Z is zero.
// - Carry-set branch jumps when C is one.
// - Carry-clear branch jumps when C is zero.
// - Same-or-higher branch jumps when C is zero.
// - Minus branch jumps when N is one.
// - Plus branch jumps when N is zero.
`timescale 1ns/100ps
module csb_unit (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic instr_valid,
   input wire csb_pkg::csb_instr_t instr,
   output logic [15:0] pc,
   output logic [7:0] status_flags,
   output logic skip_taken,
   output logic branch_taken
);
   // ********************************************************************
   // Helpers.
   // ********************************************************************

   // Relative target; offset is a signed 7-bit word count.
   function automatic logic [15:0] rel_target(input logic [15:0] cur,
                                              input logic [6:0] k);
      rel_target = cur + {{9{k[6]}}, k} + csb_pkg::PC_STEP;
   endfunction

   // ********************************************************************
   // Next-state logic.
   // ********************************************************************
   logic [15:0] next_pc;
   logic [7:0] next_status_flags;
   logic next_skip_taken;
   logic next_branch_taken;
   logic [7:0] sub_b;
   logic cin;
   logic [8:0] diff;
   logic [4:0] half;
   logic cond;
   logic is_skip;

   // Compare results only feed flags; the difference is never stored.
   always_comb begin
      next_pc = pc;
      next_status_flags = status_flags;
      next_skip_taken = 1'b0;
      next_branch_taken = 1'b0;
      cond = 1'b0;
      is_skip = 1'b0;
      cin = (instr.op == csb_pkg::CSB_COMPARE_WITH_CARRY) &
            status_flags[csb_pkg::FLAG_C];
      sub_b = instr.reg_b;
      diff = {1'b0, instr.reg_a} - {1'b0, sub_b} - {8'h00, cin};
      half = {1'b0, instr.reg_a[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, cin};
      if (instr_valid) begin
         unique case (instr.op)
            csb_pkg::CSB_COMPARE_WITH_CARRY: begin
               // Zero survives only while every byte of a chain is equal.
               next_status_flags[csb_pkg::FLAG_Z] = (diff[7:0] == 8'h00) &
                  status_flags[csb_pkg::FLAG_Z];
            end
            csb_pkg::CSB_COMPARE_IMMEDIATE: begin
               next_status_flags[csb_pkg::FLAG_Z] =
                  (diff[7:0] == 8'h00);
            end
            csb_pkg::CSB_SKIP_REG_BIT_CLEAR: begin
               is_skip = 1'b1;
               cond = ~instr.reg_a[instr.bit_sel];
            end
            csb_pkg::CSB_SKIP_REG_BIT_SET: begin
               is_skip = 1'b1;
               cond = instr.reg_a[instr.bit_sel];
            end
            csb_pkg::CSB_SKIP_IO_BIT_CLEAR: begin
               is_skip = 1'b1;
               cond = ~instr.io_val[instr.bit_sel];
            end
            csb_pkg::CSB_SKIP_IO_BIT_SET: begin
               is_skip = 1'b1;
               cond = instr.io_val[instr.bit_sel];
            end
            csb_pkg::CSB_BRANCH_FLAG_SET: begin
               cond = status_flags[instr.bit_sel];
            end
            csb_pkg::CSB_BRANCH_FLAG_CLEAR: begin
               cond = ~status_flags[instr.bit_sel];
            end
            csb_pkg::CSB_BRANCH_EQUAL: begin
               cond = status_flags[csb_pkg::FLAG_Z];
            end
            csb_pkg::CSB_BRANCH_NOT_EQUAL: begin
               cond = ~status_flags[csb_pkg::FLAG_Z];
            end
            csb_pkg::CSB_BRANCH_CARRY_SET: begin
               cond = status_flags[csb_pkg::FLAG_C];
            end
            csb_pkg::CSB_BRANCH_CARRY_CLEAR: begin
               cond = ~status_flags[csb_pkg::FLAG_C];
            end
            csb_pkg::CSB_BRANCH_SAME_OR_HIGHER: begin
               cond = ~status_flags[csb_pkg::FLAG_C];
            end
            csb_pkg::CSB_BRANCH_MINUS: begin
               cond = status_flags[csb_pkg::FLAG_N];
            end
            csb_pkg::CSB_BRANCH_PLUS: begin
               cond = ~status_flags[csb_pkg::FLAG_N];
            end
            csb_pkg::CSB_NOP: begin
               cond = 1'b0;
            end
         endcase
         if (instr.op == csb_pkg::CSB_COMPARE_WITH_CARRY ||
             instr.op == csb_pkg::CSB_COMPARE_IMMEDIATE) begin
            // Remaining flags follow the subtract.
            next_status_flags[csb_pkg::FLAG_C] = diff[8];
            next_status_flags[csb_pkg::FLAG_H] = half[4];
            next_status_flags[csb_pkg::FLAG_N] = diff[7];
            next_status_flags[csb_pkg::FLAG_V] =
               (instr.reg_a[7] & ~sub_b[7] & ~diff[7]) |
               (~instr.reg_a[7] & sub_b[7] & diff[7]);
            next_status_flags[csb_pkg::FLAG_S] =
               diff[7] ^ next_status_flags[csb_pkg::FLAG_V];
            next_pc = pc + csb_pkg::PC_STEP;
         end else if (is_skip && cond) begin
            next_skip_taken = 1'b1;
            next_pc = pc + (instr.next_two_word ? csb_pkg::SKIP_TWO_WORD :
                            csb_pkg::SKIP_ONE_WORD);
         end else if (!is_skip && cond) begin
            next_branch_taken = 1'b1;
            next_pc = rel_target(pc, instr.offset);
         end else if (instr.op != csb_pkg::CSB_NOP) begin
            next_pc = pc + csb_pkg::PC_STEP;
         end
      end
   end

   // Registers; one instruction retires per clock.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pc <= csb_pkg::PC_RESET;
         status_flags <= csb_pkg::FLAGS_RESET;
         skip_taken <= 1'b0;
         branch_taken <= 1'b0;
      end else begin
         pc <= next_pc;
         status_flags <= next_status_flags;
         skip_taken <= next_skip_taken;
         branch_taken <= next_branch_taken;
      end
   end

   // ********************************************************************
   // Checks.
   // ********************************************************************
   property p_skip_flags;
      @(posedge sys_clk) disable iff (!reset_n)
      skip_taken |-> status_flags == $past(status_flags);
   endproperty
   a_skip_flags: assert property (p_skip_flags)
      else $error("Skip changed flags.");

   property p_skip_step;
      @(posedge sys_clk) disable iff (!reset_n)
      skip_taken |-> (pc - $past(pc) == csb_pkg::SKIP_ONE_WORD) ||
                     (pc - $past(pc) == csb_pkg::SKIP_TWO_WORD);
   endproperty
   a_skip_step: assert property (p_skip_step)
      else $error("Skip step wrong.");

   property p_beq;
      @(posedge sys_clk) disable iff (!reset_n)
      instr_valid && instr.op == csb_pkg::CSB_BRANCH_EQUAL &&
      status_flags[csb_pkg::FLAG_Z] |=> branch_taken &&
      pc == $past(rel_target(pc, instr.offset));
   endproperty
   a_beq: assert property (p_beq)
      else $error("Equal branch not taken.");

   property p_bne;
      @(posedge sys_clk) disable iff (!reset_n)
      instr_valid && instr.op == csb_pkg::CSB_BRANCH_NOT_EQUAL &&
      status_flags[csb_pkg::FLAG_Z] |=> !branch_taken &&
      pc == $past(pc) + csb_pkg::PC_STEP;
   endproperty
   a_bne: assert property (p_bne)
      else $error("Not-equal branch wrongly taken.");

   property p_cpi_zero;
      @(posedge sys_clk) disable iff (!reset_n)
      instr_valid && instr.op == csb_pkg::CSB_COMPARE_IMMEDIATE &&
      instr.reg_a == instr.reg_b |=> status_flags[csb_pkg::FLAG_Z] &&
      !status_flags[csb_pkg::FLAG_C];
   endproperty
   a_cpi_zero: assert property (p_cpi_zero)
      else $error("Compare equal flags wrong.");

   property p_branch_flags;
      @(posedge sys_clk) disable iff (!reset_n)
      branch_taken |-> $stable(status_flags);
   endproperty
   a_branch_flags: assert property (p_branch_flags)
      else $error("Branch changed flags.");

   property p_bcs;
      @(posedge sys_clk) disable iff (!reset_n)
      instr_valid && instr.op == csb_pkg::CSB_BRANCH_CARRY_SET &&
      !status_flags[csb_pkg::FLAG_C] |=> !branch_taken;
   endproperty
   a_bcs: assert property (p_bcs)
      else $error("Carry-set branch wrongly taken.");

   property p_bmi;
      @(posedge sys_clk) disable iff (!reset_n)
      instr_valid && instr.op == csb_pkg::CSB_BRANCH_MINUS &&
      status_flags[csb_pkg::FLAG_N] |=> branch_taken;
   endproperty
   a_bmi: assert property (p_bmi)
      else $error("Minus branch not taken.");
endmodule

// ---- rtl/csb_pkg.sv ----
package csb_pkg;
   // ********************************************************************
   // Widths, flag positions and instruction step constants.
   // ********************************************************************
   localparam int PC_W = 16;
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_S = 3'h4;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [15:0] PC_STEP = 16'h0001;
   localparam logic [15:0] SKIP_ONE_WORD = 16'h0002;
   localparam logic [15:0] SKIP_TWO_WORD = 16'h0003;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // Operation selector presented by the decoder front end.
   typedef enum logic [3:0] {
      CSB_NOP,
      CSB_COMPARE_WITH_CARRY,
      CSB_COMPARE_IMMEDIATE,
      CSB_SKIP_REG_BIT_CLEAR,
      CSB_SKIP_REG_BIT_SET,
      CSB_SKIP_IO_BIT_CLEAR,
      CSB_SKIP_IO_BIT_SET,
      CSB_BRANCH_FLAG_SET,
      CSB_BRANCH_FLAG_CLEAR,
      CSB_BRANCH_EQUAL,
      CSB_BRANCH_NOT_EQUAL,
      CSB_BRANCH_CARRY_SET,
      CSB_BRANCH_CARRY_CLEAR,
      CSB_BRANCH_SAME_OR_HIGHER,
      CSB_BRANCH_MINUS,
      CSB_BRANCH_PLUS
   } csb_op_t;

   // One instruction as issued to the unit.
   typedef struct packed {
      csb_op_t op;
      logic [7:0] reg_a;
      logic [7:0] reg_b;
      logic [7:0] io_val;
      logic [2:0] bit_sel;
      logic [6:0] offset;
      logic next_two_word;
   } csb_instr_t;
endpackage

// ---- verification/test_compare_skip_branch_unit.sv ----
`timescale 1ns/100ps
module test_compare_skip_branch_unit;
   // ***************************************************************
   // Stimulus, expected state and the unit under test.
   // ***************************************************************
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic instr_valid = 1'b0;
   csb_pkg::csb_instr_t instr = '0;
   logic [15:0] pc;
   logic [7:0] status_flags;
   logic skip_taken;
   logic branch_taken;
   logic [15:0] e_pc = 16'h0000;
   logic [7:0] e_fl = 8'h00;
   logic e_sk = 1'b0;
   logic e_br = 1'b0;
   int fails = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [7:0] ta [4] = '{8'h10, 8'h00, 8'h80, 8'h7F};
   logic [7:0] tb [4] = '{8'h10, 8'h01, 8'h01, 8'h80};

   csb_unit dut_u (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .instr_valid(instr_valid),
      .instr(instr),
      .pc(pc),
      .status_flags(status_flags),
      .skip_taken(skip_taken),
      .branch_taken(branch_taken)
   );

   // The clock toggles every half period of 4 ns.
   always #4 sys_clk = ~sys_clk;

   // A hang is cut short well after the few hundred cycles needed.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles >= 2000) begin
         fails++;
         report_and_stop();
      end
   end

   // ***************************************************************
   // Tasks.
   // ***************************************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Compares the program counter; an unknown never passes.
   task automatic chk_pc(input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD pc expected %h seen %h", e, g);
      end
   endtask

   // Compares the whole status byte, untouched bits included.
   task automatic chk_flags(input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD flags expected %h seen %h", e, g);
      end
   endtask

   // Compares one pulse output.
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask

   // The I/O value is the inverse of the register so a wrong field shows.
   function automatic csb_pkg::csb_instr_t mk(input int op,
      input logic [7:0] a, input logic [7:0] b, input logic [2:0] s,
      input logic [6:0] k, input logic tw);
      mk = '{csb_pkg::csb_op_t'(op), a, b, ~a, s, k, tw};
   endfunction

   // Reference behaviour worked out from the instruction definitions.
   task automatic model(input csb_pkg::csb_instr_t i);
      logic [8:0] d;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] r;
      logic v;
      logic h;
      logic c;
      a = i.reg_a;
      b = i.reg_b;
      c = (i.op == csb_pkg::CSB_COMPARE_WITH_CARRY);
      e_sk = 1'b0;
      e_br = 1'b0;
      case (int'(i.op))
         1, 2: begin
            d = {1'b0, a} - {1'b0, b} - {8'h00, c & e_fl[0]};
            r = d[7:0];
            v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
            h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            e_fl = {e_fl[7:6], h, r[7] ^ v, v, r[7],
                    (r == 8'h00) & (~c | e_fl[1]), d[8]};
         end
         3: e_sk = ~a[i.bit_sel];
         4: e_sk = a[i.bit_sel];
         5: e_sk = ~i.io_val[i.bit_sel];
         6: e_sk = i.io_val[i.bit_sel];
         7: e_br = e_fl[i.bit_sel];
         8: e_br = ~e_fl[i.bit_sel];
         9: e_br = e_fl[1];
         10: e_br = ~e_fl[1];
         11: e_br = e_fl[0];
         12, 13: e_br = ~e_fl[0];
         14: e_br = e_fl[2];
         15: e_br = ~e_fl[2];
         default: ;
      endcase
      if (i.op != csb_pkg::CSB_NOP) begin
         e_pc = e_sk ? e_pc + (i.next_two_word ? 16'h0003 : 16'h0002)
              : e_br ? e_pc + {{9{i.offset[6]}}, i.offset} + 16'h0001
              : e_pc + 16'h0001;
      end
   endtask

   // Issues one instruction at an edge and checks it after the next.
   task automatic run(input csb_pkg::csb_instr_t i);
      model(i);
      instr <= i;
      instr_valid <= 1'b1;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      @(negedge sys_clk);
      chk_pc(e_pc, pc);
      chk_flags(e_fl, status_flags);
      chk_bit("skip", e_sk, skip_taken);
      chk_bit("branch", e_br, branch_taken);
      @(posedge sys_clk);
   endtask

   // ***************************************************************
   // Test sequence.
   // ***************************************************************
   initial begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(negedge sys_clk);
      chk_pc(16'h0000, pc);
      chk_flags(8'h00, status_flags);
      chk_bit("skip", 1'b0, skip_taken);
      chk_bit("branch", 1'b0, branch_taken);
      @(posedge sys_clk);
      // Corner operands, each followed by a chained compare.
      for (int j = 0; j < 4; j++) begin
         run(mk(2, ta[j], tb[j], 3'h0, 7'h00, 1'b0));
         run(mk(1, ta[j], ta[j], 3'h0, 7'h00, 1'b0));
      end
      // Every branch under two flag patterns, both offset signs.
      for (int s = 0; s < 2; s++) begin
         run(mk(2, ta[s], tb[s], 3'h0, 7'h00, 1'b0));
         for (int o = 7; o < 16; o++) begin
            for (int j = 0; j < 8; j++) begin
               run(mk(o, 8'h00, 8'h00, j[2:0], j[0] ? 7'h40 : 7'h3F,
                      1'b0));
            end
         end
      end
      // Every skip on set and clear bits, one and two word targets.
      for (int o = 3; o < 7; o++) begin
         for (int j = 0; j < 8; j++) begin
            run(mk(o, 8'hA5, 8'h00, j[2:0], 7'h00,
                   j[1]));
         end
      end
      // An empty slot changes nothing.
      run(mk(0, 8'hFF, 8'h00, 3'h0, 7'h00, 1'b0));
      report_and_stop();
   end
endmodule
